/* sdu_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module sdu_baud_gen
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [15:0] i_divisor,
    output logic o_clk_16x
);

    typedef struct packed {
        logic [15:0] cnt;
        logic clk_out;
    } sdu_baud_st_t;

    sdu_baud_st_t r;
    sdu_baud_st_t next_r;

    // Count ref cycles; output high for first half of each divisor period
    always_comb
    begin
        next_r = r;
        if (i_divisor == 16'h0000)
        begin
            next_r.cnt = 16'h0000;
            next_r.clk_out = 1'b0;
        end
        else
        begin
            if (r.cnt >= i_divisor - 16'h0001)
                next_r.cnt = 16'h0000;
            else
                next_r.cnt = r.cnt + 16'h0001;
            // Half-period worked out on 17 bits so the largest divisor does not wrap to zero
            next_r.clk_out = ({1'b0, next_r.cnt} < (({1'b0, i_divisor} + 17'h00001) >> 1));
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
            r <= '0;
        else if (i_ce)
            r <= next_r;
    end

    assign o_clk_16x = r.clk_out;

    chk_baud_count_bound: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_divisor != 16'h0000) |-> (r.cnt < i_divisor) || $changed(i_divisor))
        else $error("baud counter exceeds divisor");

endmodule : sdu_baud_gen

`default_nettype wire

/* sdu_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdu_far_model
(
    input wire logic i_ref_clk,
    input wire logic [2:0] i_line_on,
    input wire logic i_host_en,
    input wire logic [7:0] i_host_val,
    input wire logic [7:0] i_dev_data,
    input wire logic i_dev_oe_n,
    output logic o_clear_to_send_n,
    output logic o_data_set_ready_n,
    output logic o_carrier_detect_n,
    output logic [7:0] o_bus
);
    // Modem lines are active low and change only after a falling edge
    initial
    begin
        o_clear_to_send_n = 1'b1;
        o_data_set_ready_n = 1'b1;
        o_carrier_detect_n = 1'b1;
    end
    always @(negedge i_ref_clk)
    begin
        o_clear_to_send_n <= ~i_line_on[0];
        o_data_set_ready_n <= ~i_line_on[1];
        o_carrier_detect_n <= ~i_line_on[2];
    end
    // Bus level: device when enabled, else host, else pulled high
    assign o_bus = !i_dev_oe_n ? i_dev_data : (i_host_en ? i_host_val : 8'hff);
endmodule : sdu_far_model

`default_nettype wire

/* sdu_host_modem.sv */
// How it works
// - Host drives three select inputs on every access; they choose the register.
// - While address strobe is low, selects feed the decode straight through.
// - Rising address strobe captures selects; captured values used while it stays high.
// - Selected only when both high selects high and low select low.
// - Transmit 16x clock output is reference clock divided by divisor latch.
// - Status bit 4 shows clear-to-send; bit 0 flags its change since read.
// - Clear-to-send change interrupts only if modem irq enabled and autoflow off.
// - In autoflow mode clear-to-send gates the transmitter.
// - Status bit 5 shows data-set-ready; bit 1 flags change; may interrupt.
// - Status bit 7 shows carrier; bit 3 flags change; may interrupt.
// - Terminal-ready active per control bit; inactive on reset, loopback or clear.
// - Driver-disable output high whenever the host is not reading.
// - Interrupt output for enabled rx error, rx data/timeout, tx empty, modem.
// - Interrupt output drops once sources are serviced or on master reset.
// - Master reset clears most registers and sets terminal-ready, interrupt and tx-allowed outputs to reset levels.
// - Eight-bit bus driven only during selected reads, released otherwise.
// - Read when selected and either read strobe active; unused one held inactive.
`timescale 1ns/1ps
`default_nettype none

module sdu_host_modem
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_reg_select_bit0,
    input wire logic i_reg_select_bit1,
    input wire logic i_reg_select_bit2,
    input wire logic i_address_latch_strobe_n,
    input wire logic i_select_high_first,
    input wire logic i_select_high_second,
    input wire logic i_select_low_n,
    input wire logic i_read_strobe_n,
    input wire logic i_read_strobe_p,
    input wire logic i_write_strobe_n,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    output logic o_bus_driver_disable,
    input wire logic i_clear_to_send_n,
    input wire logic i_data_set_ready_n,
    input wire logic i_carrier_detect_n,
    input wire logic i_master_reset,
    input wire logic i_rx_error,
    input wire logic i_rx_data_ready,
    input wire logic i_rx_timeout,
    input wire logic i_fifo_mode,
    input wire logic i_tx_holding_empty,
    output logic o_terminal_ready_n,
    output logic o_irq_out,
    output logic o_tx_allowed,
    output logic o_tx_16x_clock_out
);

    // Pin sample, packed so both synchroniser stages share one layout
    typedef struct packed {
        logic [2:0] rsel;
        logic cs_hi1;
        logic cs_hi2;
        logic cs_lo_n;
        logic ads_n;
        logic rd_n;
        logic rd_p;
        logic wr_n;
        logic [7:0] data;
        logic cts_n;
        logic dsr_n;
        logic dcd_n;
        logic mr;
    } sdu_pins_t;

    typedef struct packed {
        sdu_pins_t s1;
        sdu_pins_t s2;
        logic [2:0] lat_rsel;
        logic lat_sel;
        logic rd_d;
        logic wr_d;
        logic [3:0] ier;
        logic [7:0] lcr;
        logic [5:0] mcr;
        logic [15:0] div;
        logic [7:0] scr;
        logic cts_prev;
        logic dsr_prev;
        logic dcd_prev;
        logic d_cts;
        logic d_dsr;
        logic d_dcd;
        logic [7:0] dout;
        logic oe_n;
        logic bus_driver_disable;
        logic dtr_n;
        logic irq;
        logic tx_ok;
    } sdu_st_t;

    // Idle pin levels: read/write strobes and modem lines inactive, address strobe low
    localparam sdu_pins_t PINS_IDLE = '{rsel: 3'h0, cs_hi1: 1'b0, cs_hi2: 1'b0, cs_lo_n: 1'b1,
        ads_n: 1'b0, rd_n: 1'b1, rd_p: 1'b0, wr_n: 1'b1, data: 8'h00,
        cts_n: 1'b1, dsr_n: 1'b1, dcd_n: 1'b1, mr: 1'b0};

    sdu_st_t r;
    sdu_st_t next_r;
    sdu_pins_t pins_now;
    logic [2:0] eff_rsel;
    logic eff_sel;
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic wr_start;
    logic dlab;
    logic [7:0] msr_val;
    logic modem_irq;
    logic cts_lvl;
    logic dsr_lvl;
    logic dcd_lvl;

    // Register-select match, aware of the divisor access bit
    function automatic logic hits(input logic [2:0] addr, input logic [2:0] off,
                                  input logic div_acc, input logic want_div);
        hits = (addr == off) && (div_acc == want_div);
    endfunction : hits

    assign pins_now = '{rsel: {i_reg_select_bit2, i_reg_select_bit1, i_reg_select_bit0},
        cs_hi1: i_select_high_first, cs_hi2: i_select_high_second, cs_lo_n: i_select_low_n,
        ads_n: i_address_latch_strobe_n, rd_n: i_read_strobe_n, rd_p: i_read_strobe_p,
        wr_n: i_write_strobe_n, data: i_data, cts_n: i_clear_to_send_n,
        dsr_n: i_data_set_ready_n, dcd_n: i_carrier_detect_n, mr: i_master_reset};

    // Select decode: transparent while strobe low, held values while high
    always_comb
    begin
        if (!r.s2.ads_n)
        begin
            eff_rsel = r.s2.rsel;
            eff_sel = r.s2.cs_hi1 && r.s2.cs_hi2 && !r.s2.cs_lo_n;
        end
        else
        begin
            eff_rsel = r.lat_rsel;
            eff_sel = r.lat_sel;
        end
    end

    // Access qualifiers and modem status image
    assign rd_act = eff_sel && (!r.s2.rd_n || r.s2.rd_p);
    assign wr_act = eff_sel && !r.s2.wr_n;
    assign rd_start = rd_act && !r.rd_d;
    assign wr_start = wr_act && !r.wr_d;
    assign dlab = r.lcr[sdu_pkg::LCR_DIV_ACCESS];
    assign cts_lvl = !r.s2.cts_n;
    assign dsr_lvl = !r.s2.dsr_n;
    assign dcd_lvl = !r.s2.dcd_n;
    assign modem_irq = (r.d_cts && !r.mcr[sdu_pkg::MCR_AUTOFLOW]) || r.d_dsr || r.d_dcd;

    always_comb
    begin
        msr_val = 8'h00;
        msr_val[sdu_pkg::MSR_CTS] = cts_lvl;
        msr_val[sdu_pkg::MSR_CTS_CHANGED] = r.d_cts;
        msr_val[sdu_pkg::MSR_DSR] = dsr_lvl;
        msr_val[sdu_pkg::MSR_DSR_CHANGED] = r.d_dsr;
        msr_val[sdu_pkg::MSR_CARRIER] = dcd_lvl;
        msr_val[sdu_pkg::MSR_CARRIER_CHANGED] = r.d_dcd;
    end

    // Next-state logic for the whole block
    always_comb
    begin
        next_r = r;
        next_r.s1 = pins_now;
        next_r.s2 = r.s1;
        next_r.lat_rsel = eff_rsel;
        next_r.lat_sel = eff_sel;
        next_r.rd_d = rd_act;
        next_r.wr_d = wr_act;
        next_r.cts_prev = cts_lvl;
        next_r.dsr_prev = dsr_lvl;
        next_r.dcd_prev = dcd_lvl;
        // Change bits: a fresh change wins over a clearing read
        next_r.d_cts = r.d_cts;
        next_r.d_dsr = r.d_dsr;
        next_r.d_dcd = r.d_dcd;
        if (rd_start && hits(eff_rsel, sdu_pkg::OFF_MODEM_STAT, dlab, dlab))
        begin
            next_r.d_cts = 1'b0;
            next_r.d_dsr = 1'b0;
            next_r.d_dcd = 1'b0;
        end
        next_r.d_cts = next_r.d_cts || (cts_lvl != r.cts_prev);
        next_r.d_dsr = next_r.d_dsr || (dsr_lvl != r.dsr_prev);
        next_r.d_dcd = next_r.d_dcd || (dcd_lvl != r.dcd_prev);
        // Read data captured at the start of a read
        if (rd_start)
        begin
            if (hits(eff_rsel, sdu_pkg::OFF_DIV_LO, dlab, 1'b1))
                next_r.dout = r.div[7:0];
            else if (hits(eff_rsel, sdu_pkg::OFF_DIV_HI, dlab, 1'b1))
                next_r.dout = r.div[15:8];
            else if (hits(eff_rsel, sdu_pkg::OFF_IRQ_EN, dlab, 1'b0))
                next_r.dout = {4'h0, r.ier};
            else if (eff_rsel == sdu_pkg::OFF_LINE_CTRL)
                next_r.dout = r.lcr;
            else if (eff_rsel == sdu_pkg::OFF_MODEM_CTRL)
                next_r.dout = {2'h0, r.mcr};
            else if (eff_rsel == sdu_pkg::OFF_MODEM_STAT)
                next_r.dout = msr_val;
            else if (eff_rsel == sdu_pkg::OFF_SCRATCH)
                next_r.dout = r.scr;
            else
                next_r.dout = 8'h00;
        end
        next_r.oe_n = !rd_act;
        next_r.bus_driver_disable = !rd_act;
        // Register writes from the host bus
        if (wr_start)
        begin
            if (hits(eff_rsel, sdu_pkg::OFF_DIV_LO, dlab, 1'b1))
                next_r.div[7:0] = r.s2.data;
            else if (hits(eff_rsel, sdu_pkg::OFF_DIV_HI, dlab, 1'b1))
                next_r.div[15:8] = r.s2.data;
            else if (hits(eff_rsel, sdu_pkg::OFF_IRQ_EN, dlab, 1'b0))
                next_r.ier = r.s2.data[3:0];
            else if (eff_rsel == sdu_pkg::OFF_LINE_CTRL)
                next_r.lcr = r.s2.data;
            else if (eff_rsel == sdu_pkg::OFF_MODEM_CTRL)
                next_r.mcr = r.s2.data[5:0];
            else if (eff_rsel == sdu_pkg::OFF_SCRATCH)
                next_r.scr = r.s2.data;
        end
        // Outputs follow the control registers
        next_r.dtr_n = !(r.mcr[sdu_pkg::MCR_TERM_READY] && !r.mcr[sdu_pkg::MCR_LOOPBACK]);
        next_r.tx_ok = !r.mcr[sdu_pkg::MCR_AUTOFLOW] || cts_lvl;
        next_r.irq = (r.ier[sdu_pkg::IEN_RX_ERROR] && i_rx_error)
            || (r.ier[sdu_pkg::IEN_RX_DATA] && (i_rx_data_ready || (i_fifo_mode && i_rx_timeout)))
            || (r.ier[sdu_pkg::IEN_TX_EMPTY] && i_tx_holding_empty)
            || (r.ier[sdu_pkg::IEN_MODEM] && modem_irq);
        // Master reset clears control registers except the divisor and resets the dtr_n, irq and tx_ok levels
        if (r.s2.mr)
        begin
            next_r.ier = sdu_pkg::IER_RESET;
            next_r.lcr = sdu_pkg::LCR_RESET;
            next_r.mcr = sdu_pkg::MCR_RESET;
            next_r.scr = sdu_pkg::SCR_RESET;
            next_r.d_cts = 1'b0;
            next_r.d_dsr = 1'b0;
            next_r.d_dcd = 1'b0;
            next_r.dtr_n = 1'b1;
            next_r.irq = 1'b0;
            next_r.tx_ok = 1'b1;
        end
    end

    // State register with sync reset and clock enable
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            r <= '0;
            r.s1 <= PINS_IDLE;
            r.s2 <= PINS_IDLE;
            r.cts_prev <= 1'b0;
            r.dsr_prev <= 1'b0;
            r.dcd_prev <= 1'b0;
            r.div <= sdu_pkg::DIV_RESET;
            r.oe_n <= 1'b1;
            r.bus_driver_disable <= 1'b1;
            r.dtr_n <= 1'b1;
            r.tx_ok <= 1'b1;
        end
        else if (i_ce)
            r <= next_r;
    end

    // Baud divider for the 16x transmit clock
    sdu_baud_gen u_baud
    (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_divisor(r.div),
        .o_clk_16x(o_tx_16x_clock_out)
    );

    assign o_data = r.dout;
    assign o_data_oe_n = r.oe_n;
    assign o_bus_driver_disable = r.bus_driver_disable;
    assign o_terminal_ready_n = r.dtr_n;
    assign o_irq_out = r.irq;
    assign o_tx_allowed = r.tx_ok;

    // Checks on the host and modem behaviour
    chk_bus_drive_bus_driver_disable: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !o_data_oe_n |-> !o_bus_driver_disable)
        else $error("bus driven while driver disable high");

    chk_unselected_idle: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && !eff_sel) |=> o_data_oe_n)
        else $error("bus driven while not selected");

    chk_read_drives_bus: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && rd_act) |=> !o_data_oe_n)
        else $error("selected read did not drive bus");

    chk_loop_dtr_off: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && r.mcr[sdu_pkg::MCR_LOOPBACK]) |=> o_terminal_ready_n)
        else $error("terminal ready active in loopback");

    chk_msr_cts_level: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && rd_start && eff_rsel == sdu_pkg::OFF_MODEM_STAT)
        |=> o_data[sdu_pkg::MSR_CTS] == !$past(r.s2.cts_n))
        else $error("status bit 4 does not follow clear to send");

    chk_delta_clears: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && !r.s2.mr && rd_start && eff_rsel == sdu_pkg::OFF_MODEM_STAT
         && cts_lvl == r.cts_prev && dsr_lvl == r.dsr_prev && dcd_lvl == r.dcd_prev)
        |=> !r.d_cts && !r.d_dsr && !r.d_dcd)
        else $error("change bits survived status read");

    chk_irq_masked_off: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && r.ier == 4'h0) |=> !o_irq_out)
        else $error("interrupt with all sources disabled");

    chk_autoflow_cts_irq: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && r.ier == 4'h8 && r.mcr[sdu_pkg::MCR_AUTOFLOW] && !r.d_dsr && !r.d_dcd)
        |=> !o_irq_out)
        else $error("clear to send change interrupted in autoflow");

    chk_master_reset_out: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && r.s2.mr) |=> (!o_irq_out && o_terminal_ready_n))
        else $error("master reset left outputs active");

    chk_tx_gate_cts: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (i_ce && r.mcr[sdu_pkg::MCR_AUTOFLOW] && r.s2.cts_n && !r.s2.mr) |=> !o_tx_allowed)
        else $error("transmitter not gated by clear to send");

endmodule : sdu_host_modem

`default_nettype wire

/* sdu_pkg.sv */
`default_nettype none

package sdu_pkg;
    // Register offsets on the three select inputs
    localparam logic [2:0] OFF_DIV_LO = 3'h0;
    localparam logic [2:0] OFF_IRQ_EN = 3'h1;
    localparam logic [2:0] OFF_DIV_HI = 3'h1;
    localparam logic [2:0] OFF_LINE_CTRL = 3'h3;
    localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFF_MODEM_STAT = 3'h6;
    localparam logic [2:0] OFF_SCRATCH = 3'h7;
    // Interrupt enable bit positions
    localparam int IEN_RX_DATA = 0;
    localparam int IEN_TX_EMPTY = 1;
    localparam int IEN_RX_ERROR = 2;
    localparam int IEN_MODEM = 3;
    // Line control: divisor latch access bit
    localparam int LCR_DIV_ACCESS = 7;
    // Modem control bit positions
    localparam int MCR_TERM_READY = 0;
    localparam int MCR_LOOPBACK = 4;
    localparam int MCR_AUTOFLOW = 5;
    // Modem status bit positions
    localparam int MSR_CTS_CHANGED = 0;
    localparam int MSR_DSR_CHANGED = 1;
    localparam int MSR_CARRIER_CHANGED = 3;
    localparam int MSR_CTS = 4;
    localparam int MSR_DSR = 5;
    localparam int MSR_CARRIER = 7;
    // Reset values
    localparam logic [3:0] IER_RESET = 4'h0;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [5:0] MCR_RESET = 6'h00;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [7:0] SCR_RESET = 8'h00;
endpackage : sdu_pkg

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top;
    logic clk, srst, ce, ads_n, cs1, cs2, cs3_n, rd_n, rd_p, wr_n, host_en, mreset, rx_to, fifo;
    logic [2:0] rs, line_on, src;
    logic [7:0] host_val, r, ex, o_data;
    logic [7:0] data_bus;
    logic oe_n, bus_driver_disable, term_n, irq, tx_ok, baud, cts_n, dsr_n, dcd_n, bus_driver_disable_seen;
    int err_total, samples_checked, n;
    localparam int CHG [3] = '{sdu_pkg::MSR_CTS_CHANGED, sdu_pkg::MSR_DSR_CHANGED, sdu_pkg::MSR_CARRIER_CHANGED};
    localparam int LVL [3] = '{sdu_pkg::MSR_CTS, sdu_pkg::MSR_DSR, sdu_pkg::MSR_CARRIER};

    sdu_host_modem u_dut (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_reg_select_bit0(rs[0]),
        .i_reg_select_bit1(rs[1]), .i_reg_select_bit2(rs[2]), .i_address_latch_strobe_n(ads_n),
        .i_select_high_first(cs1), .i_select_high_second(cs2), .i_select_low_n(cs3_n),
        .i_read_strobe_n(rd_n), .i_read_strobe_p(rd_p), .i_write_strobe_n(wr_n), .i_data(data_bus),
        .o_data(o_data), .o_data_oe_n(oe_n), .o_bus_driver_disable(bus_driver_disable), .i_clear_to_send_n(cts_n),
        .i_data_set_ready_n(dsr_n), .i_carrier_detect_n(dcd_n), .i_master_reset(mreset),
        .i_rx_error(src[2]), .i_rx_data_ready(src[0]), .i_rx_timeout(rx_to), .i_fifo_mode(fifo),
        .i_tx_holding_empty(src[1]), .o_terminal_ready_n(term_n), .o_irq_out(irq),
        .o_tx_allowed(tx_ok), .o_tx_16x_clock_out(baud));

    sdu_far_model u_far (.i_ref_clk(clk), .i_line_on(line_on), .i_host_en(host_en), .i_host_val(host_val),
        .i_dev_data(o_data), .i_dev_oe_n(oe_n), .o_clear_to_send_n(cts_n), .o_data_set_ready_n(dsr_n),
        .o_carrier_detect_n(dcd_n), .o_bus(data_bus));

    // Clock generation
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Verdict and end of run
    task automatic give_verdict();
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Host write: data settles two cycles before the strobe and is held past it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        rs = a;
        host_val = d;
        host_en = 1'b1;
        repeat (2) @(negedge clk);
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (2) @(negedge clk);
        host_en = 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr

    // Host read on either strobe; an unanswered read sees the pulled-up bus
    task automatic rd(input logic [2:0] a, input logic use_p, output logic [7:0] d);
        int i;
        @(negedge clk);
        rs = a;
        if (use_p)
            rd_p = 1'b1;
        else
            rd_n = 1'b0;
        for (i = 0; i < 8 && oe_n !== 1'b0; i++)
            @(negedge clk);
        d = data_bus;
        bus_driver_disable_seen = bus_driver_disable;
        rd_n = 1'b1;
        rd_p = 1'b0;
        repeat (6) @(negedge clk);
    endtask : rd

    // Watchdog against a hung sequence
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        {srst, ce, ads_n, cs1, cs2, cs3_n, rd_n, rd_p, wr_n} = 9'b110110101;
        {host_en, mreset, rx_to, fifo, rs, line_on, src, host_val} = '0;
        err_total = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        `CHK("oe_n", 1'b1, oe_n)
        `CHK("bus_driver_disable", 1'b1, bus_driver_disable)
        `CHK("term_n", 1'b1, term_n)
        `CHK("irq", 1'b0, irq)
        `CHK("baud", 1'b0, baud)
        foreach (CHG[k])
        begin
            wr(sdu_pkg::OFF_SCRATCH, 8'ha5 ^ 8'(k * 8'hff));
            rd(sdu_pkg::OFF_SCRATCH, 1'b0, r);
            `CHK("scratch", 8'ha5 ^ 8'(k * 8'hff), r)
            `CHK("bus_driver_disable_rd", 1'b0, bus_driver_disable_seen)
            `CHK("oe_idle", 1'b1, oe_n)
        end
        rd(sdu_pkg::OFF_SCRATCH, 1'b1, r);
        `CHK("rd_p", 8'h5b, r)
        for (int i = 0; i < 3; i++)
        begin
            cs1 = (i != 0);
            cs2 = (i != 1);
            cs3_n = (i == 2);
            wr(sdu_pkg::OFF_SCRATCH, 8'h3c);
            rd(sdu_pkg::OFF_SCRATCH, 1'b0, r);
            `CHK("unsel", 8'hff, r)
            {cs1, cs2, cs3_n} = 3'b110;
        end
        rd(sdu_pkg::OFF_SCRATCH, 1'b0, r);
        `CHK("kept", 8'h5b, r)
        // Latch offset 7, then access through other select values
        rs = 3'h7;
        repeat (3) @(negedge clk);
        ads_n = 1'b1;
        wr(3'h2, 8'h11);
        rd(3'h0, 1'b0, r);
        `CHK("latched", 8'h11, r)
        ads_n = 1'b0;
        rd(3'h2, 1'b0, r);
        `CHK("transp", 8'h00, r)
        wr(sdu_pkg::OFF_MODEM_CTRL, 8'h01);
        `CHK("dtr_on", 1'b0, term_n)
        wr(sdu_pkg::OFF_MODEM_CTRL, 8'h11);
        `CHK("dtr_loop", 1'b1, term_n)
        wr(sdu_pkg::OFF_MODEM_CTRL, 8'h01);
        wr(sdu_pkg::OFF_IRQ_EN, 8'h02);
        src[1] = 1'b1;
        mreset = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("dtr_mr", 1'b1, term_n)
        `CHK("irq_mr", 1'b0, irq)
        mreset = 1'b0;
        src[1] = 1'b0;
        repeat (4) @(negedge clk);
        // Modem lines one by one: level, change flag, interrupt, clear on read
        wr(sdu_pkg::OFF_IRQ_EN, 8'h08);
        ex = 8'h00;
        foreach (CHG[k])
        begin
            line_on[k] = 1'b1;
            repeat (8) @(negedge clk);
            `CHK("irq_mdm", 1'b1, irq)
            ex[LVL[k]] = 1'b1;
            rd(sdu_pkg::OFF_MODEM_STAT, 1'b0, r);
            `CHK("msr_chg", ex | (8'h01 << CHG[k]), r)
            `CHK("irq_clr", 1'b0, irq)
            rd(sdu_pkg::OFF_MODEM_STAT, 1'b0, r);
            `CHK("msr_lvl", ex, r)
        end
        wr(sdu_pkg::OFF_MODEM_CTRL, 8'h20);
        line_on[0] = 1'b0;
        repeat (8) @(negedge clk);
        `CHK("irq_af", 1'b0, irq)
        `CHK("tx_gate", 1'b0, tx_ok)
        rd(sdu_pkg::OFF_MODEM_STAT, 1'b0, r);
        `CHK("msr_af", 8'ha1, r)
        line_on[0] = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("tx_open", 1'b1, tx_ok)
        rd(sdu_pkg::OFF_MODEM_STAT, 1'b0, r);
        // Other sources: masked, enabled, serviced
        for (int k = 0; k < 3; k++)
        begin
            wr(sdu_pkg::OFF_IRQ_EN, 8'h00);
            src[k] = 1'b1;
            repeat (4) @(negedge clk);
            `CHK("irq_mask", 1'b0, irq)
            wr(sdu_pkg::OFF_IRQ_EN, 8'h01 << k);
            `CHK("irq_src", 1'b1, irq)
            src[k] = 1'b0;
            repeat (3) @(negedge clk);
            `CHK("irq_drop", 1'b0, irq)
        end
        wr(sdu_pkg::OFF_IRQ_EN, 8'h01);
        rx_to = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("to_char", 1'b0, irq)
        fifo = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("to_fifo", 1'b1, irq)
        // Divisor of four gives a four-cycle baud period
        wr(sdu_pkg::OFF_LINE_CTRL, 8'h80);
        wr(sdu_pkg::OFF_DIV_LO, 8'h04);
        wr(sdu_pkg::OFF_DIV_HI, 8'h00);
        wr(sdu_pkg::OFF_LINE_CTRL, 8'h00);
        for (int i = 0; i < 20 && !(baud === 1'b0); i++)
            @(negedge clk);
        for (int i = 0; i < 20 && !(baud === 1'b1); i++)
            @(negedge clk);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (n < 20 && !(baud === 1'b1 && n > 1));
        `CHK("baud_per", 4, n)
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
